// [core/acr_checksum.sv]
/*
  Register map checksum engine: folds the covered register words into a
  CRC-16, one word per clock, and holds the last finished result.
  Assumes the words stay stable or that any change is followed by a start.
*/
`timescale 1ns/1ps
module acr_checksum
  import acr_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire logic                   enable,
  input  wire logic                   start,
  input  wire logic [5:0][15:0]       words,
  output logic      [15:0]            sum,
  output logic                        busy
);

  typedef struct packed {
    acr_ck_state_t state;
    logic [2:0]    idx;
    logic [15:0]   crc;
    logic [15:0]   sum;
  } acr_ck_regs_t;

  acr_ck_regs_t r;
  acr_ck_regs_t n;

  function automatic logic [15:0] acr_crc_word(input logic [15:0] crc,
                                               input logic [15:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ ACR_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  always_comb begin
    n = r;
    unique case (r.state)
      ACR_CK_IDLE: begin
      end
      ACR_CK_RUN: begin
        n.crc = acr_crc_word(r.crc, words[r.idx]);
        n.idx = r.idx + 3'h1;
        if (r.idx == ACR_CK_LAST) begin
          n.sum   = acr_crc_word(r.crc, words[r.idx]);
          n.state = ACR_CK_IDLE;
        end
      end
    endcase
    // A new change restarts the walk so a stale partial result is never kept
    if (start) begin
      n.state = ACR_CK_RUN;
      n.idx   = 3'h0;
      n.crc   = ACR_CRC_INIT;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r.state <= ACR_CK_IDLE;
      r.idx   <= 3'h0;
      r.crc   <= ACR_CRC_INIT;
      r.sum   <= ACR_RST_CKSUM;
    end else if (enable) begin
      r <= n;
    end
  end

  assign sum  = r.sum;
  assign busy = (r.state == ACR_CK_RUN);

endmodule

// [core/acr_pkg.sv]
/*
  Constants and types shared by the channel 1 calibration and configuration
  register bank and its register map checksum engine.
  Assumes a 16-bit register word reached through a 6-bit register address.
*/
package acr_pkg;

  localparam int unsigned ACR_AW = 6;
  localparam int unsigned ACR_DW = 16;

  // Register addresses
  localparam logic [5:0] ACR_ADDR_CFG     = 6'h0e;
  localparam logic [5:0] ACR_ADDR_OFS_HI  = 6'h0f;
  localparam logic [5:0] ACR_ADDR_OFS_LO  = 6'h10;
  localparam logic [5:0] ACR_ADDR_GAIN_HI = 6'h11;
  localparam logic [5:0] ACR_ADDR_GAIN_LO = 6'h12;
  localparam logic [5:0] ACR_ADDR_CKSUM   = 6'h3e;
  localparam logic [5:0] ACR_ADDR_SPARE   = 6'h3f;

  // Field positions in the configuration word
  localparam int unsigned ACR_PHASE_MSB = 15;
  localparam int unsigned ACR_PHASE_LSB = 6;
  localparam int unsigned ACR_PHASE_W   = 10;
  localparam int unsigned ACR_DCB_BIT   = 2;
  localparam int unsigned ACR_SEL_MSB   = 1;
  localparam int unsigned ACR_SEL_LSB   = 0;

  // Calibration low word: value byte in the upper half
  localparam int unsigned ACR_CAL_LO_MSB = 15;
  localparam int unsigned ACR_CAL_LO_LSB = 8;
  localparam int unsigned ACR_CAL_W      = 24;

  // Writable bits; all others read as zero
  localparam logic [15:0] ACR_CFG_WMASK    = 16'hffc7;
  localparam logic [15:0] ACR_CAL_LO_WMASK = 16'hff00;

  // Values after reset
  localparam logic [15:0] ACR_RST_CFG     = 16'h0000;
  localparam logic [15:0] ACR_RST_OFS_HI  = 16'h0000;
  localparam logic [15:0] ACR_RST_OFS_LO  = 16'h0000;
  localparam logic [15:0] ACR_RST_GAIN_HI = 16'h8000;
  localparam logic [15:0] ACR_RST_GAIN_LO = 16'h0000;
  localparam logic [15:0] ACR_RST_CKSUM   = 16'h0000;
  localparam logic [15:0] ACR_RST_SPARE   = 16'h0000;

  // Checksum: CRC-16 over the covered words, lowest address first
  localparam logic [15:0] ACR_CRC_POLY  = 16'h1021;
  localparam logic [15:0] ACR_CRC_INIT  = 16'hffff;
  localparam int unsigned ACR_CK_WORDS  = 6;
  localparam logic [2:0]  ACR_CK_LAST   = 3'h5;

  typedef enum logic [1:0] {
    ACR_SEL_EXT   = 2'b00,
    ACR_SEL_SHORT = 2'b01,
    ACR_SEL_POS   = 2'b10,
    ACR_SEL_NEG   = 2'b11
  } acr_sel_t;

  typedef enum logic [0:0] {
    ACR_CK_IDLE = 1'b0,
    ACR_CK_RUN  = 1'b1
  } acr_ck_state_t;

endpackage

// [core/acr_regs.sv]
/*
  Channel 1 configuration and calibration register bank with a read-only
  register map checksum word and one spare word.
  Assumes a master that issues one-cycle read or write strobes synchronous to
  clock; read data appear in the cycle after the read strobe only.
*/
`timescale 1ns/1ps
module acr_regs
  import acr_pkg::*;
#(
  parameter int unsigned AW = ACR_AW
)
(
  input  wire logic [AW-1:0]          reg_addr,
  input  wire logic [15:0]            wr_data,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire logic                   enable,
  input  wire logic [3:0]             global_dc_block_setting,
  output logic      [15:0]            rd_data,
  output logic                        rd_valid,
  output logic      [9:0]             ch1_phase_delay,
  output logic                        ch1_dc_block_off,
  output logic                        ch1_dc_block_active,
  output acr_sel_t                    ch1_input_select,
  output logic                        ch1_use_ext_inputs,
  output logic      [23:0]            ch1_offset_cal,
  output logic      [23:0]            ch1_gain_cal,
  output logic                        cksum_busy
);

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] ofs_hi;
    logic [15:0] ofs_lo;
    logic [15:0] gain_hi;
    logic [15:0] gain_lo;
    logic [15:0] spare;
    logic [15:0] rd_data;
    logic        rd_valid;
  } acr_regs_t;

  acr_regs_t        r;
  acr_regs_t        n;
  logic [15:0]      cksum;
  logic [5:0][15:0] ck_words;
  logic             ck_start;
  logic [5:0]       addr6;

  assign addr6 = 6'(reg_addr);

  function automatic logic acr_covered(input logic [5:0] a);
    return (a == ACR_ADDR_CFG) || (a == ACR_ADDR_OFS_HI) || (a == ACR_ADDR_OFS_LO) ||
           (a == ACR_ADDR_GAIN_HI) || (a == ACR_ADDR_GAIN_LO) || (a == ACR_ADDR_SPARE);
  endfunction

  always_comb begin
    n          = r;
    n.rd_valid = 1'b0;
    n.rd_data  = 16'h0000;
    if (wr_stb) begin
      unique case (addr6)
        ACR_ADDR_CFG:     n.cfg     = wr_data & ACR_CFG_WMASK;
        ACR_ADDR_OFS_HI:  n.ofs_hi  = wr_data;
        ACR_ADDR_OFS_LO:  n.ofs_lo  = wr_data & ACR_CAL_LO_WMASK;
        ACR_ADDR_GAIN_HI: n.gain_hi = wr_data;
        ACR_ADDR_GAIN_LO: n.gain_lo = wr_data & ACR_CAL_LO_WMASK;
        // Stored as written; software keeps it zero, hardware does not police it
        ACR_ADDR_SPARE:   n.spare   = wr_data;
        default: begin
          // Checksum word and unmapped addresses ignore writes
        end
      endcase
    end
    if (rd_stb) begin
      n.rd_valid = 1'b1;
      unique case (addr6)
        ACR_ADDR_CFG:     n.rd_data = r.cfg;
        ACR_ADDR_OFS_HI:  n.rd_data = r.ofs_hi;
        ACR_ADDR_OFS_LO:  n.rd_data = r.ofs_lo;
        ACR_ADDR_GAIN_HI: n.rd_data = r.gain_hi;
        ACR_ADDR_GAIN_LO: n.rd_data = r.gain_lo;
        ACR_ADDR_CKSUM:   n.rd_data = cksum;
        ACR_ADDR_SPARE:   n.rd_data = r.spare;
        default:          n.rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r.cfg      <= ACR_RST_CFG;
      r.ofs_hi   <= ACR_RST_OFS_HI;
      r.ofs_lo   <= ACR_RST_OFS_LO;
      r.gain_hi  <= ACR_RST_GAIN_HI;
      r.gain_lo  <= ACR_RST_GAIN_LO;
      r.spare    <= ACR_RST_SPARE;
      r.rd_data  <= 16'h0000;
      r.rd_valid <= 1'b0;
    end else if (enable) begin
      r <= n;
    end
  end

  // Engine walks the words after the write edge, so it sees the new value
  assign ck_start = wr_stb && acr_covered(addr6);
  assign ck_words = {r.spare, r.gain_lo, r.gain_hi, r.ofs_lo, r.ofs_hi, r.cfg};

  acr_checksum u_cksum (
    .clock   (clock),
    .reset_n (reset_n),
    .enable  (enable),
    .start   (ck_start),
    .words   (ck_words),
    .sum     (cksum),
    .busy    (cksum_busy)
  );

  assign rd_data  = r.rd_data;
  assign rd_valid = r.rd_valid;

  assign ch1_phase_delay     = r.cfg[ACR_PHASE_MSB:ACR_PHASE_LSB];
  assign ch1_dc_block_off    = r.cfg[ACR_DCB_BIT];
  assign ch1_dc_block_active = !r.cfg[ACR_DCB_BIT] && (|global_dc_block_setting);
  assign ch1_input_select    = acr_sel_t'(r.cfg[ACR_SEL_MSB:ACR_SEL_LSB]);
  assign ch1_use_ext_inputs  = (ch1_input_select == ACR_SEL_EXT);
  assign ch1_offset_cal      = {r.ofs_hi,
                                r.ofs_lo[ACR_CAL_LO_MSB:ACR_CAL_LO_LSB]};
  assign ch1_gain_cal        = {r.gain_hi,
                                r.gain_lo[ACR_CAL_LO_MSB:ACR_CAL_LO_LSB]};

endmodule

// [verification/acr_regs_sva.sv]
/*
  Port checker for the channel 1 register bank.
  Assumes it is bound to acr_regs and sees only its ports.
*/
`timescale 1ns/1ps
module acr_regs_sva
  import acr_pkg::*;
#(
  parameter int unsigned AW = ACR_AW
)
(
  input wire logic [AW-1:0] reg_addr,
  input wire logic [15:0]   wr_data,
  input wire logic          wr_stb,
  input wire logic          rd_stb,
  input wire logic          clock,
  input wire logic          reset_n,
  input wire logic          enable,
  input wire logic [3:0]    global_dc_block_setting,
  input wire logic [15:0]   rd_data,
  input wire logic          rd_valid,
  input wire logic [9:0]    ch1_phase_delay,
  input wire logic          ch1_dc_block_off,
  input wire logic          ch1_dc_block_active,
  input wire acr_sel_t      ch1_input_select,
  input wire logic          ch1_use_ext_inputs,
  input wire logic [23:0]   ch1_offset_cal,
  input wire logic [23:0]   ch1_gain_cal,
  input wire logic          cksum_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Enable low freezes the bank, so only enabled strobes count
  wire       w    = enable && wr_stb;
  wire [7:0] wtop = wr_data[15:8];
  wire       cov  = w && (reg_addr inside {6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h3f});
  property p_cfg;
    logic [15:0] v;
    (w && reg_addr == ACR_ADDR_CFG, v = wr_data) |=> ch1_phase_delay == v[15:6]
      && ch1_dc_block_off == v[2] && ch1_input_select == v[1:0];
  endproperty
  chk_cfg_write: assert property (p_cfg) else $error("cfg fields");
  chk_cfg_rsvd: assert property (rd_valid && $past(reg_addr) == ACR_ADDR_CFG
    |-> rd_data[5:3] == 3'h0) else $error("cfg reserved bits");
  chk_low_rsvd: assert property (rd_valid && $past(reg_addr) inside {6'h10, 6'h12}
    |-> rd_data[7:0] == 8'h00) else $error("low byte");
  chk_dcb_act: assert property (ch1_dc_block_active
    == (!ch1_dc_block_off && |global_dc_block_setting)) else $error("dc block");
  chk_ext_sel: assert property (ch1_use_ext_inputs
    == (ch1_input_select == ACR_SEL_EXT)) else $error("ext decode");
  chk_ofs_hi: assert property (w && reg_addr == ACR_ADDR_OFS_HI
    |=> ch1_offset_cal[23:8] == $past(wr_data)) else $error("offset high");
  chk_ofs_lo: assert property (w && reg_addr == ACR_ADDR_OFS_LO
    |=> ch1_offset_cal[7:0] == $past(wtop)) else $error("offset low");
  chk_gain_hi: assert property (w && reg_addr == ACR_ADDR_GAIN_HI
    |=> ch1_gain_cal[23:8] == $past(wr_data)) else $error("gain high");
  chk_gain_lo: assert property (w && reg_addr == ACR_ADDR_GAIN_LO
    |=> ch1_gain_cal[7:0] == $past(wtop)) else $error("gain low");
  // Read data must not leak a stale word outside its one valid cycle
  chk_rd_idle: assert property (!rd_valid |-> rd_data == 16'h0000)
    else $error("read data idle");
  chk_ck_start: assert property (cov |=> cksum_busy) else $error("no walk");
  chk_ck_len: assert property ($fell(cksum_busy) |-> $past(cksum_busy, 6))
    else $error("walk short");
  cover property (cov ##1 cksum_busy[*6] ##1 !cksum_busy);
  cover property (rd_valid && $past(reg_addr) == ACR_ADDR_CKSUM);
  cover property (w && reg_addr == ACR_ADDR_CKSUM);
endmodule

// [verification/tb.sv]
/*
  Self-checking bench for the channel 1 register bank.
  Assumes acr_pkg, acr_regs and acr_regs_sva are compiled first.
*/
`timescale 1ns/1ps
module tb import acr_pkg::*;;
  logic        clock = 0, reset_n = 0, enable = 1, wr_stb = 0, rd_stb = 0, ck_on = 0;
  logic [5:0]  reg_addr = '0;
  logic [15:0] wr_data = '0, rd_data, q, d;
  logic [3:0]  global_dc_block_setting = '0;
  logic        rd_valid, ch1_dc_block_off, ch1_dc_block_active, ch1_use_ext_inputs, cksum_busy;
  logic [9:0]  ch1_phase_delay;
  logic [23:0] ch1_offset_cal, ch1_gain_cal;
  acr_sel_t    ch1_input_select;
  logic [15:0] m [64];
  logic [5:0]  ads [7] = '{6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h3e, 6'h3f};
  int          seed = 72116, mismatches = 0, n_compared = 0, cycles = 0, i, k, r;

  always #12.5 clock = ~clock;
  acr_regs i_acr_regs (.*);

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done;
    end
  end

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Covered words in address order, spare word last
  function automatic logic [15:0] crc_of();
    logic [15:0] c = ACR_CRC_INIT;
    for (int j = 0; j < 6; j++)
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ m[ads[j + j / 5]][b]) ? ACR_CRC_POLY : 16'h0000);
    return c;
  endfunction

  task wr(input logic [5:0] a, input logic [15:0] v, input logic en);
    @(posedge clock);
    reg_addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    enable <= en;
    global_dc_block_setting <= 4'($random(seed));
    @(posedge clock);
    wr_stb <= 1'b0;
    enable <= 1'b1;
    if (en && a inside {6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h3f}) begin
      m[a] = (a == 6'h0e) ? v & ACR_CFG_WMASK
           : (a inside {6'h10, 6'h12}) ? v & ACR_CAL_LO_WMASK : v;
      ck_on = 1'b1;
    end
  endtask

  task rd(input logic [5:0] a);
    @(posedge clock);
    reg_addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 q = rd_data;
    cmp("rd_valid", 24'h1, rd_valid);
  endtask

  // Waits out the walk, counting its cycles in k, then reads the whole map
  task check_all;
    k = 0;
    #1 while (cksum_busy !== 1'b0 && k < 50) begin
      @(posedge clock);
      #1 k++;
    end
    for (i = 0; i < 7; i++) begin
      rd(ads[i]);
      d = (i == 5) ? (ck_on ? crc_of() : 16'h0000) : m[ads[i]];
      cmp("register", d, q);
    end
    rd(6'h2a);
    cmp("unmapped", 24'h0, q);
    cmp("offset_cal", {m[6'h0f], m[6'h10][15:8]}, ch1_offset_cal);
    cmp("gain_cal", {m[6'h11], m[6'h12][15:8]}, ch1_gain_cal);
  endtask

  initial begin
    for (i = 0; i < 64; i++) m[i] = 16'h0000;
    m[6'h11] = 16'h8000;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    check_all;
    for (r = 0; r < 4; r++) begin
      d = 16'($random(seed));
      d[2:0] = {r[0], r[1:0]};
      wr(6'h0e, d, 1'b1);
      #1 cmp("select", d[1:0], ch1_input_select);
      cmp("ext_inputs", d[1:0] == 2'b00, ch1_use_ext_inputs);
      cmp("phase", d[15:6], ch1_phase_delay);
      cmp("dc_off", d[2], ch1_dc_block_off);
      cmp("dc_active", !d[2] && |global_dc_block_setting, ch1_dc_block_active);
    end
    wr(6'h0f, 16'h8001, 1'b1);
    check_all;
    cmp("busy_cycles", 24'h6, 24'(k));
    wr(6'h3e, 16'hffff, 1'b1);
    wr(6'h10, 16'hffff, 1'b1);
    wr(6'h12, 16'hffff, 1'b1);
    wr(6'h3f, 16'h0000, 1'b1);
    check_all;
    for (i = 0; i < 80; i++) begin
      r = $unsigned($random(seed)) % 9;
      d = (r == 6) ? 16'h0000 : 16'($random(seed));
      wr(r < 7 ? ads[r] : 6'h2a, d, ($random(seed) & 7) != 0);
    end
    check_all;
    // Mid-run reset must bring back every value after reset, checksum included
    @(posedge clock);
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    for (i = 0; i < 64; i++) m[i] = 16'h0000;
    m[6'h11] = 16'h8000;
    ck_on = 1'b0;
    check_all;
    test_done;
  end
endmodule

bind acr_regs acr_regs_sva #(.AW(AW)) i_acr_regs_sva (.*);
